// ---- eds_divide.sv ----
`timescale 1ns/100ps
`include "eds_divide_map.svh"
module eds_divide
    import eds_pkg::*;
#(
    parameter int SETUP_CYC = `EDS_SETUP_CYC, // Setup wait in clocks
    parameter int BASE_CYC = `EDS_BASE_CYC, // Fixed part of arithmetic time
    parameter int STEP_CYC = `EDS_STEP_CYC // Clocks per counted step
)(
    input wire logic mclk, // 100 MHz clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic wb_cyc_i, // Bus cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    output logic irq // Level interrupt
);

    // ****************************************
    // Reset release and state
    // ****************************************
    logic [1:0] rst_sync;
    logic rst_n_sync;
    eds_regs_t s;
    eds_regs_t n;
    logic alu_shift;
    logic alu_fix;
    logic alu_temp;
    logic [17:0] alu_ac;
    logic [17:0] alu_mq;
    logic [17:0] indicator;
    logic bus_req;
    logic bus_wr;
    logic start;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [6:0] sc_inc;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_sync <= 2'h0;
        end
        else
        begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_sync[1];

    function automatic eds_kind_t op_kind(input logic [17:0] ins);
        logic [11:0] code;
        code = ins[17:6];
        // Signed variants differ from unsigned in one instruction bit only
        code[`EDS_SIGNED_BIT - 6] = 1'b0;
        if (code == `EDS_DOUBLE_QUOTIENT_OP)
        begin
            return EDS_K_DOUBLE;
        end
        else if (code == `EDS_INTEGER_QUOTIENT_OP)
        begin
            return EDS_K_INTEGER;
        end
        else if (code == `EDS_FRACTION_QUOTIENT_OP)
        begin
            return EDS_K_FRACTION;
        end
        else
        begin
            return EDS_K_NONE;
        end
    endfunction : op_kind

    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    eds_step_alu u_alu (
        .do_shift(alu_shift),
        .do_fix(alu_fix),
        .temp_i(s.temp),
        .ac_i(s.accumulator_reg),
        .mq_i(s.quotient_extension_reg),
        .divisor_i(s.memory_operand_reg),
        .temp_o(alu_temp),
        .ac_o(alu_ac),
        .mq_o(alu_mq)
    );
    assign alu_shift = (s.st == EDS_EV_E);
    assign alu_fix = (s.st == EDS_EV_F);
    assign sc_inc = s.step_counter_reg + 7'h01;

    // ****************************************
    // Indicator word, every function complemented
    // ****************************************
    always_comb
    begin
        indicator = 18'h3ffff;
        for (int i = 0; i < 6; i++)
        begin
            indicator[17 - i] = ~s.st[i + 1];
        end
        indicator[17 - 8] = ~(s.st == EDS_EV_E);
        indicator[17 - 13] = ~s.sign_flag;
        indicator[17 - 14] = ~s.result_negate_flag;
        indicator[17 - 15] = ~s.div_overflow;
        indicator[17 - 16] = ~s.step_count_full;
        indicator[17 - 17] = ~s.shift_suppress_flag;
    end

    // ****************************************
    // Register read mux
    // ****************************************
    always_comb
    begin
        rdat = 32'h0;
        if (wb_adr_i == `EDS_CMD_OFS)
        begin
            rdat[17:0] = s.instr;
        end
        else if (wb_adr_i == `EDS_ACC_OFS)
        begin
            rdat[17:0] = s.accumulator_reg;
        end
        else if (wb_adr_i == `EDS_QUO_OFS)
        begin
            rdat[17:0] = s.quotient_extension_reg;
        end
        else if (wb_adr_i == `EDS_OPND_OFS)
        begin
            rdat[17:0] = s.memory_operand_reg;
        end
        else if (wb_adr_i == `EDS_LINK_OFS)
        begin
            rdat[0] = s.link;
        end
        else if (wb_adr_i == `EDS_STATUS_OFS)
        begin
            rdat[`EDS_ST_BUSY] = (s.st != EDS_IDLE);
            rdat[`EDS_ST_OVF] = s.div_overflow;
            rdat[`EDS_ST_SIGN] = s.sign_flag;
            rdat[`EDS_ST_NEG] = s.result_negate_flag;
            rdat[`EDS_ST_FULL] = s.step_count_full;
            rdat[`EDS_ST_NOSHIFT] = s.shift_suppress_flag;
            rdat[`EDS_ST_SC_LSB +: 7] = s.step_counter_reg;
        end
        else if (wb_adr_i == `EDS_IND_OFS)
        begin
            rdat[17:0] = indicator;
        end
        else if (wb_adr_i == `EDS_ISTAT_OFS)
        begin
            rdat[1:0] = s.irq_status;
        end
        else if (wb_adr_i == `EDS_IMASK_OFS)
        begin
            rdat[1:0] = s.irq_mask;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        n = s;
        n.ack = 1'b0;
        bus_req = wb_cyc_i & wb_stb_i & ~s.ack;
        bus_wr = bus_req & wb_we_i;
        wdat = lane_merge(rdat, wb_dat_i, wb_sel_i);
        start = 1'b0;
        if (bus_req)
        begin
            n.ack = 1'b1;
            n.dat = rdat;
        end
        // Operands are frozen while an operation runs
        if (bus_wr)
        begin
            if (wb_adr_i == `EDS_CMD_OFS)
            begin
                start = (s.st == EDS_IDLE) && (op_kind(wdat[17:0]) != EDS_K_NONE);
            end
            else if (wb_adr_i == `EDS_ACC_OFS && s.st == EDS_IDLE)
            begin
                n.accumulator_reg = wdat[17:0];
            end
            else if (wb_adr_i == `EDS_QUO_OFS && s.st == EDS_IDLE)
            begin
                n.quotient_extension_reg = wdat[17:0];
            end
            else if (wb_adr_i == `EDS_OPND_OFS && s.st == EDS_IDLE)
            begin
                n.memory_operand_reg = wdat[17:0];
            end
            else if (wb_adr_i == `EDS_LINK_OFS && s.st == EDS_IDLE)
            begin
                n.link = wdat[0];
            end
            else if (wb_adr_i == `EDS_ISTAT_OFS)
            begin
                // Unselected lane must not clear, so no merge with the old value
                n.irq_status = s.irq_status & ~(wb_dat_i[1:0] & {2{wb_sel_i[0]}});
            end
            else if (wb_adr_i == `EDS_IMASK_OFS)
            begin
                n.irq_mask = wdat[1:0];
            end
        end
        if (s.wait_cnt != 9'h0)
        begin
            n.wait_cnt = s.wait_cnt - 9'h001;
        end
        // Sticky sets below come after the clear, so an event wins
        case (s.st)
            EDS_IDLE:
            begin
                if (start)
                begin
                    n.instr = wdat[17:0];
                    n.kind = op_kind(wdat[17:0]);
                    n.is_signed = wdat[`EDS_SIGNED_BIT];
                    n.temp = 1'b0;
                    n.sign_flag = 1'b0;
                    n.result_negate_flag = 1'b0;
                    n.div_overflow = 1'b0;
                    n.step_count_full = 1'b0;
                    n.shift_suppress_flag = 1'b0;
                    n.st = EDS_EV_A;
                end
            end
            EDS_EV_A:
            begin
                n.step_counter_reg = {1'b0, 6'(6'h00 - s.instr[5:0])};
                if (s.is_signed)
                begin
                    n.sign_flag = s.accumulator_reg[17];
                    n.result_negate_flag = s.link ^ s.accumulator_reg[17];
                end
                if (s.kind == EDS_K_INTEGER)
                begin
                    // Upper dividend half is zero at the start of the run
                    n.quotient_extension_reg = (s.is_signed && s.accumulator_reg[17]) ?
                                               ~s.accumulator_reg : s.accumulator_reg;
                    n.accumulator_reg = `EDS_WORD_RESET;
                end
                else if (s.is_signed && s.accumulator_reg[17])
                begin
                    n.accumulator_reg = ~s.accumulator_reg;
                end
                n.st = EDS_EV_B;
            end
            EDS_EV_B:
            begin
                if (s.kind == EDS_K_FRACTION)
                begin
                    // Signed fraction: bit 0 is cleared by the complement, point sits after it
                    n.quotient_extension_reg = `EDS_WORD_RESET;
                end
                else if (s.kind == EDS_K_DOUBLE && s.sign_flag)
                begin
                    n.quotient_extension_reg = ~s.quotient_extension_reg;
                end
                n.st = EDS_EV_C;
            end
            EDS_EV_C:
            begin
                n.step_counter_reg = sc_inc;
                if (!alu_temp)
                begin
                    // Divisor not above the upper half, quotient cannot fit
                    n.link = 1'b1;
                    n.div_overflow = 1'b1;
                    n.irq_status[`EDS_IRQ_OVF] = 1'b1;
                    n.irq_status[`EDS_IRQ_DONE] = 1'b1;
                    n.st = EDS_IDLE;
                end
                else
                begin
                    n.temp = alu_temp;
                    n.accumulator_reg = alu_ac;
                    n.step_count_full = sc_inc[6];
                    n.wait_cnt = 9'(SETUP_CYC - 1);
                    n.st = EDS_EV_D;
                end
            end
            EDS_EV_D:
            begin
                if (s.wait_cnt == 9'h0)
                begin
                    n.shift_suppress_flag = s.step_count_full;
                    n.wait_cnt = s.step_count_full ? 9'(BASE_CYC - 1) : 9'(STEP_CYC - 1);
                    n.st = s.step_count_full ? EDS_EV_F : EDS_EV_E;
                end
            end
            EDS_EV_E:
            begin
                if (s.wait_cnt == 9'h0)
                begin
                    // Same sequence for all three kinds
                    n.temp = alu_temp;
                    n.accumulator_reg = alu_ac;
                    n.quotient_extension_reg = alu_mq;
                    n.step_counter_reg = sc_inc;
                    if (sc_inc[6])
                    begin
                        // Counter reached zero, last quotient bit shifts alone
                        n.step_count_full = 1'b1;
                        n.shift_suppress_flag = 1'b1;
                        n.wait_cnt = 9'(BASE_CYC - 1);
                        n.st = EDS_EV_F;
                    end
                    else
                    begin
                        n.wait_cnt = 9'(STEP_CYC - 1);
                    end
                end
            end
            EDS_EV_F:
            begin
                if (s.wait_cnt == 9'h0)
                begin
                    n.temp = alu_temp;
                    n.accumulator_reg = s.sign_flag ? ~alu_ac : alu_ac;
                    n.quotient_extension_reg = s.result_negate_flag ? ~alu_mq : alu_mq;
                    n.irq_status[`EDS_IRQ_DONE] = 1'b1;
                    n.st = EDS_IDLE;
                end
            end
            default:
            begin
                n.st = EDS_IDLE;
            end
        endcase
        n.irq_out = |(s.irq_status & s.irq_mask);
    end

    always_ff @(posedge mclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            s <= '{st: EDS_IDLE, kind: EDS_K_NONE, irq_mask: `EDS_IMASK_RESET, default: '0};
        end
        else
        begin
            s <= n;
        end
    end

    assign wb_dat_o = s.dat;
    assign wb_ack_o = s.ack;
    assign irq = s.irq_out;

    // ****************************************
    // Checks
    // ****************************************
    localparam int SETUP_LAST = SETUP_CYC - 1;
    logic [8:0] dwell;
    always_ff @(posedge mclk or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            dwell <= 9'h0;
        end
        else
        begin
            dwell <= (n.st == s.st) ? dwell + 9'h001 : 9'h0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_sync);

    sequence seq_prep;
        s.st == EDS_EV_A ##1 s.st == EDS_EV_B ##1 s.st == EDS_EV_C;
    endsequence
    sequence seq_signed_a;
        s.st == EDS_EV_A && s.is_signed;
    endsequence

    a_start_runs_prep: assert property (start |=> seq_prep)
        else $error("Start did not run preparation A B C");
    a_integer_copy: assert property (s.st == EDS_EV_A && s.kind == EDS_K_INTEGER && !s.is_signed
        |=> s.quotient_extension_reg == $past(s.accumulator_reg) && s.accumulator_reg == 18'h0)
        else $error("Integer prep did not move accumulator");
    a_fraction_clear: assert property (s.st == EDS_EV_B && s.kind == EDS_K_FRACTION
        |=> s.quotient_extension_reg == 18'h0)
        else $error("Fraction prep did not clear extension");
    a_counter_load: assert property (s.st == EDS_EV_A
        |=> s.step_counter_reg[5:0] == 6'(6'h00 - $past(s.instr[5:0])) && !s.step_counter_reg[6])
        else $error("Step counter not loaded with negated count");
    a_overflow_abort: assert property (s.st == EDS_EV_C && !alu_temp
        |=> s.link && s.div_overflow && s.st == EDS_IDLE)
        else $error("Divide overflow did not set link and abort");
    a_setup_time: assert property (s.st == EDS_EV_D && n.st != EDS_EV_D |-> dwell == 9'(SETUP_LAST))
        else $error("Setup wait has wrong length");
    a_step_shift: assert property (s.st == EDS_EV_E && s.wait_cnt == 9'h0
        |=> s.quotient_extension_reg[0] == !$past(s.temp)
        && s.quotient_extension_reg[17:1] == $past(s.quotient_extension_reg[16:0]))
        else $error("Step did not shift in the quotient bit");
    a_sign_flags: assert property (seq_signed_a
        |=> s.sign_flag == $past(s.accumulator_reg[17])
        && s.result_negate_flag == ($past(s.link) != $past(s.accumulator_reg[17])))
        else $error("Sign or negate flag wrong");
    a_indicator_view: assert property (s.st == EDS_EV_E
        |-> indicator[13] == 1'b0 && indicator[1] == !s.step_count_full)
        else $error("Indicator does not reflect state");
    a_stop_at_zero: assert property (s.st == EDS_EV_E && sc_inc[6] && s.wait_cnt == 9'h0
        |=> s.st == EDS_EV_F && s.shift_suppress_flag)
        else $error("Arithmetic did not stop at zero count");

endmodule : eds_divide

// ---- eds_divide_map.svh ----
// What this block does
// - Unsigned and signed double-length quotient are decoded from octal codes 6403XX and 6443XX, low two digits being the step count.
// - Integer quotient divides the accumulator by the next memory word, quotient to the extension register, remainder to the accumulator.
// - Integer quotient preparation copies the accumulator into the extension register and then clears the accumulator.
// - Integer quotient arithmetic runs the double-length step sequence with the upper dividend half at zero.
// - Fraction quotient divides the accumulator fraction by the next memory word, quotient and remainder placed as for integer.
// - Fraction quotient preparation clears the extension register so the long dividend has a zero low half.
// - Unsigned fraction has its binary point left of accumulator bit 0, signed fraction between bits 0 and 1.
// - The extension register is 18 bits and the step counter 7 bits (six count plus overflow), both visible to software.
// - Twelve control functions are shown complemented, positions 0-5 event times, 8 event E, 13-17 sign, negate, overflow, full, no-shift.
// - An operation takes 1.32 us of setup, then 2.75 us plus 260 ns for each counted arithmetic step.
// - Preparation loads the step counter with the two's complement of instruction bits 12-17; arithmetic stops at zero.
// - Each step first shifts both registers left, then adds the divisor after a negative result and subtracts after a positive one.
// - If the first subtraction shows the divisor not above the accumulator half, the link is set and the operation aborts.
// - Signed forms set the sign flag from accumulator bit 0, the negate flag when link differs, and complement accordingly.
`ifndef EDS_DIVIDE_MAP_SVH
`define EDS_DIVIDE_MAP_SVH

// ****************************************
// Operation codes, instruction bits 17..6
// ****************************************
`define EDS_DOUBLE_QUOTIENT_OP 12'hd03
`define EDS_SIGNED_DOUBLE_QUOTIENT_OP 12'hd23
`define EDS_INTEGER_QUOTIENT_OP 12'hd5b
`define EDS_SIGNED_INTEGER_QUOTIENT_OP 12'hd7b
`define EDS_FRACTION_QUOTIENT_OP 12'hd43
`define EDS_SIGNED_FRACTION_QUOTIENT_OP 12'hd63
`define EDS_SIGNED_BIT 11

// ****************************************
// Register byte offsets
// ****************************************
`define EDS_CMD_OFS 8'h00
`define EDS_ACC_OFS 8'h04
`define EDS_QUO_OFS 8'h08
`define EDS_OPND_OFS 8'h0c
`define EDS_LINK_OFS 8'h10
`define EDS_STATUS_OFS 8'h14
`define EDS_IND_OFS 8'h18
`define EDS_ISTAT_OFS 8'h1c
`define EDS_IMASK_OFS 8'h20

// ****************************************
// Field positions and reset values
// ****************************************
`define EDS_ST_BUSY 0
`define EDS_ST_OVF 1
`define EDS_ST_SIGN 2
`define EDS_ST_NEG 3
`define EDS_ST_FULL 4
`define EDS_ST_NOSHIFT 5
`define EDS_ST_SC_LSB 8
`define EDS_IRQ_DONE 0
`define EDS_IRQ_OVF 1
`define EDS_IMASK_RESET 2'h0
`define EDS_WORD_RESET 18'h00000

// ****************************************
// Timing
// ****************************************
`define EDS_CLK_PERIOD_NS 10
`define EDS_SETUP_NS 1320
`define EDS_BASE_NS 2750
`define EDS_STEP_NS 260
`define EDS_SETUP_CYC ((`EDS_SETUP_NS + `EDS_CLK_PERIOD_NS - 1) / `EDS_CLK_PERIOD_NS)
`define EDS_BASE_CYC ((`EDS_BASE_NS + `EDS_CLK_PERIOD_NS - 1) / `EDS_CLK_PERIOD_NS)
`define EDS_STEP_CYC ((`EDS_STEP_NS + `EDS_CLK_PERIOD_NS - 1) / `EDS_CLK_PERIOD_NS)

`endif

// ---- eds_pkg.sv ----
package eds_pkg;

    // Event-time states, bit i+1 is event time i
    typedef enum logic [6:0] {
        EDS_IDLE = 7'h01,
        EDS_EV_A = 7'h02,
        EDS_EV_B = 7'h04,
        EDS_EV_C = 7'h08,
        EDS_EV_D = 7'h10,
        EDS_EV_E = 7'h20,
        EDS_EV_F = 7'h40
    } eds_state_t;

    typedef enum logic [3:0] {
        EDS_K_NONE = 4'h1,
        EDS_K_DOUBLE = 4'h2,
        EDS_K_INTEGER = 4'h4,
        EDS_K_FRACTION = 4'h8
    } eds_kind_t;

    typedef struct packed {
        eds_state_t st;
        eds_kind_t kind;
        logic is_signed;
        logic [17:0] instr;
        logic [17:0] accumulator_reg;
        logic [17:0] quotient_extension_reg;
        logic [17:0] memory_operand_reg;
        logic link;
        logic temp;
        logic [6:0] step_counter_reg;
        logic sign_flag;
        logic result_negate_flag;
        logic div_overflow;
        logic step_count_full;
        logic shift_suppress_flag;
        logic [8:0] wait_cnt;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic ack;
        logic [31:0] dat;
        logic irq_out;
    } eds_regs_t;

endpackage : eds_pkg

// ---- eds_step_alu.sv ----
`timescale 1ns/100ps
module eds_step_alu
    import eds_pkg::*;
(
    input wire logic do_shift, // Shift long register before add/subtract
    input wire logic do_fix, // Final quotient bit and remainder restore
    input wire logic temp_i, // Sign of partial remainder
    input wire logic [17:0] ac_i, // Partial remainder
    input wire logic [17:0] mq_i, // Dividend low half / quotient
    input wire logic [17:0] divisor_i, // Divisor magnitude
    output logic temp_o, // New remainder sign
    output logic [17:0] ac_o, // New partial remainder
    output logic [17:0] mq_o // New quotient extension
);

    logic [19:0] pr;
    logic [19:0] dv;
    logic [19:0] sum;

    always_comb
    begin
        dv = {2'b00, divisor_i};
        pr = {temp_i, temp_i, ac_i};
        if (do_fix)
        begin
            // Negative remainder is restored, no shift of the remainder
            sum = temp_i ? pr + dv : pr;
            mq_o = {mq_i[16:0], ~temp_i};
        end
        else
        begin
            if (do_shift)
            begin
                pr = {temp_i, ac_i, mq_i[17]};
            end
            // Negative remainder adds, positive subtracts
            sum = temp_i ? pr + dv : pr - dv;
            mq_o = do_shift ? {mq_i[16:0], ~temp_i} : mq_i;
        end
        temp_o = sum[18];
        ac_o = sum[17:0];
    end

endmodule : eds_step_alu

// ---- eds_cpu_model.sv ----
`timescale 1ns/100ps
// ****************
// Processor side bus master
// ****************
module eds_cpu_model (
    input wire logic mclk, // Clock
    output logic cyc, // Cycle
    output logic stb, // Strobe
    output logic we, // Write enable
    output logic [7:0] adr, // Address
    output logic [3:0] sel, // Lanes
    output logic [31:0] dat, // Write data
    input wire logic [31:0] rdat, // Read data
    input wire logic ack // Acknowledge
);
    initial
    begin
        {cyc, stb, we, sel, adr} = 15'h0;
        dat = 32'h0;
    end
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        begin
            @(posedge mclk);
            {cyc, stb, we} <= {2'h3, w};
            adr <= a;
            sel <= 4'hf;
            dat <= d;
            n = 0;
            do
            begin
                @(posedge mclk);
                n++;
            end
            while (ack !== 1'b1 && n < 40);
            q = rdat;
            {cyc, stb, we} <= 3'h0;
            dat <= ~d; // Released data must not look valid
            if (ack !== 1'b1)
                tb_top.lose();
        end
    endtask : xfer
endmodule : eds_cpu_model

// ---- tb_top.sv ----
`timescale 1ns/100ps
// ****************
// Divide block bench
// ****************
module tb_top;
    logic mclk, nrst, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rd, q;
    int num_errors = 0;
    int checks = 0;
    eds_divide #(.SETUP_CYC(2), .BASE_CYC(3), .STEP_CYC(2)) uut (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
        .wb_ack_o(ack), .irq(irq));
    eds_cpu_model cpu (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wd),
        .rdat(rd), .ack(ack));
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task conclude;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task lose;
        num_errors++;
        $display("unexpected wait expected answer seen none");
        conclude();
    endtask : lose
    task wr(input logic [7:0] a, input logic [31:0] d);
        cpu.xfer(1'b1, a, d, q);
    endtask : wr
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task rdc(input logic [7:0] a, input logic [31:0] e);
        cpu.xfer(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask : rdc
    // Times are taken from the ack edge of the start write
    task run(input logic [17:0] ins, ac, qu, op, input logic lk, input int t, input logic [31:0] ist, eq, er);
        int n;
        begin
            wr(8'h04, {14'h0, ac});
            wr(8'h08, {14'h0, qu});
            wr(8'h0c, {14'h0, op});
            wr(8'h10, {31'h0, lk});
            wr(8'h00, {14'h0, ins});
            n = 0;
            while (irq !== 1'b1 && n < 300)
            begin
                @(posedge mclk);
                n++;
            end
            if (irq !== 1'b1)
                lose();
            chk("duration", 32'h1, {31'h0, n >= t - 2 && n <= t + 3});
            rdc(8'h1c, ist);
            if (ist == 32'h1)
            begin
                rdc(8'h08, eq);
                rdc(8'h04, er);
            end
            wr(8'h1c, 32'h3);
            rdc(8'h1c, 32'h0);
        end
    endtask : run
    initial
    begin
        nrst = 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
        rdc(8'h18, 32'h3ffff);
        rdc(8'h20, 32'h0);
        wr(8'h08, 32'hffffffff);
        rdc(8'h08, 32'h3ffff);
        wr(8'h20, 32'h3);
        run(18'h340d3, 18'h3, 18'h13, 18'h5, 1'b0, 44, 32'h1, 32'h2666a, 32'h1);
        run(18'h348d3, 18'h0, 18'h64, 18'h7, 1'b1, 44, 32'h1, 32'h3fff1, 32'h2);
        run(18'h356d3, 18'h64, 18'h3ffff, 18'h7, 1'b0, 44, 32'h1, 32'he, 32'h2);
        run(18'h35ed3, 18'h3ff9b, 18'h0, 18'h7, 1'b0, 44, 32'h1, 32'h3fff1, 32'h3fffd);
        run(18'h350d3, 18'h1, 18'h3ffff, 18'h3, 1'b0, 44, 32'h1, 32'h15555, 32'h1);
        run(18'h358d3, 18'h1, 18'h3ffff, 18'h3, 1'b0, 44, 32'h1, 32'h15555, 32'h1);
        run(18'h340d3, 18'h9, 18'h0, 18'h5, 1'b0, 3, 32'h3, 32'h0, 32'h0);
        rdc(8'h10, 32'h1);
        rdc(8'h14, 32'h2e02);
        rdc(8'h18, 32'h3fffb);
        // Done is masked now, so the finished divide must stay quiet
        wr(8'h20, 32'h2);
        wr(8'h10, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h340d3);
        repeat (60) @(posedge mclk);
        chk("irq", 32'h0, {31'h0, irq});
        rdc(8'h1c, 32'h1);
        conclude();
    end
endmodule : tb_top
